/* sse_status_port.sv */
// serial port with status/control registers and a byte shift engine
// assumes a single ahb-lite master and a link clock that keeps running
`timescale 1ns/1ns

// Behaviour
// - the port runs either as an spi port or as an i2c port, never both at once.
// - as spi master, sample phase 1 samples input at the end of the output time, 0 at its middle.
// - in i2c use, sample phase 1 turns output slew control off and 0 turns it on.
// - with the clock idling high and edge select 1, output data changes on the falling edge.
module sse_status_port (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial link
  input wire logic sdi,
  output sse_pkg::sse_spi_out_t spi_o,
  output logic slew_ctrl_en
);

  sse_pkg::sse_ref_t r_q, r_d;
  sse_pkg::sse_lnk_t l_q, l_d;
  logic take;
  logic busy;
  logic done_evt;
  logic start_evt;
  logic shpar;
  logic samp_w;
  logic shift_w;
  sse_pkg::sse_cfg_t c;

  // register side: bus slave, config, byte handshake
  always_comb
  begin
    r_d = r_q;
    take = hsel && hready && htrans[1];
    busy = r_q.start_tgl ^ r_q.done_sy[2];
    done_evt = r_q.done_sy[1] ^ r_q.done_sy[2];
    r_d.done_sy = {r_q.done_sy[1:0], l_q.done_tgl};
    r_d.ready = 1'b1;
    r_d.resp = 1'b0;
    // word stays stable in the link domain until its toggle is seen
    if (done_evt)
    begin
      r_d.rx = l_q.rx;
    end
    // data phase of a write; word writes only
    r_d.aw = 1'b0;
    if (r_q.aw)
    begin
      case (r_q.aaddr)
        sse_pkg::ADDR_STATUS:
        begin
          r_d.status[sse_pkg::STAT_SMP] = hwdata[sse_pkg::STAT_SMP];
          r_d.status[sse_pkg::STAT_CKE] = hwdata[sse_pkg::STAT_CKE];
        end
        sse_pkg::ADDR_CTRL: r_d.ctrl = hwdata[7:0] & sse_pkg::CTRL_WMASK;
        sse_pkg::ADDR_DATA:
        begin
          // a byte written while one is in flight is dropped
          if (!busy)
          begin
            r_d.tx = hwdata[7:0];
            r_d.start_tgl = ~r_q.start_tgl;
          end
        end
        default: r_d.aw = 1'b0;
      endcase
    end
    // address phase: decode and fetch read data now, zero wait
    if (take)
    begin
      r_d.aw = hwrite;
      r_d.aaddr = haddr;
      r_d.rdata = 32'h0000_0000;
      if (!hwrite)
      begin
        case (haddr)
          sse_pkg::ADDR_STATUS: r_d.rdata = {24'h00_0000, r_q.status};
          sse_pkg::ADDR_CTRL: r_d.rdata = {24'h00_0000, r_q.ctrl};
          sse_pkg::ADDR_DATA:
          begin
            r_d.rdata = {24'h00_0000, r_q.rx};
            r_d.status[sse_pkg::STAT_BF] = 1'b0;
          end
          default: r_d.rdata = 32'h0000_0000;
        endcase
      end
    end
    // a completed byte beats a clearing read in the same cycle
    if (done_evt)
    begin
      r_d.status[sse_pkg::STAT_BF] = 1'b1;
    end
    // slew control only matters in i2c use
    r_d.slew = r_q.ctrl[sse_pkg::CTRL_I2C] && !r_q.status[sse_pkg::STAT_SMP];
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q <= sse_pkg::REF_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign hreadyout = r_q.ready;
  assign hresp = r_q.resp;
  assign hrdata = r_q.rdata;
  assign slew_ctrl_en = r_q.slew;

  // link side: config levels synced, start toggle synced, byte shifter
  always_comb
  begin
    l_d = l_q;
    l_d.rst_sy = {l_q.rst_sy[0], rst};
    l_d.c1 = '{input_sample_phase: r_q.status[sse_pkg::STAT_SMP], cke: r_q.status[sse_pkg::STAT_CKE],
               clock_idle_polarity: r_q.ctrl[sse_pkg::CTRL_CKP], i2c: r_q.ctrl[sse_pkg::CTRL_I2C],
               en: r_q.ctrl[sse_pkg::CTRL_EN]};
    l_d.c2 = l_q.c1;
    l_d.st_sy = {l_q.st_sy[1:0], r_q.start_tgl};
    l_d.sdi_sy = {l_q.sdi_sy[0], sdi};
    c = l_q.c2;
    start_evt = l_q.st_sy[1] ^ l_q.st_sy[2];
    // edge select 0 shifts on trailing edges, 1 on leading edges
    shpar = !c.cke;
    shift_w = (l_q.e[0] == shpar) && !l_q.e[4];
    // middle sampling takes the opposite edge, end sampling the shift edge
    samp_w = 1'b0;
    if (!l_q.e[4])
    begin
      if (l_q.e[0] != shpar)
      begin
        samp_w = !c.input_sample_phase;
      end
      else
      begin
        samp_w = c.input_sample_phase && !(c.cke && l_q.e == 5'h00);
      end
    end
    else if (l_q.state == sse_pkg::SSE_SHIFT)
    begin
      samp_w = c.cke && c.input_sample_phase;
    end
    case (l_q.state)
      sse_pkg::SSE_IDLE:
      begin
        l_d.pin.sck = c.clock_idle_polarity;
        if (start_evt && c.en && !c.i2c)
        begin
          l_d.e = 5'h00;
          l_d.state = sse_pkg::SSE_SHIFT;
          if (c.cke)
          begin
            l_d.txr = r_q.tx;
          end
          else
          begin
            l_d.pin.sdo = r_q.tx[7];
            l_d.txr = {r_q.tx[6:0], 1'b0};
          end
        end
        else if (start_evt)
        begin
          // shifter off or in i2c use: hand the byte straight back
          l_d.done_tgl = ~l_q.done_tgl;
        end
      end
      sse_pkg::SSE_SHIFT:
      begin
        if (samp_w)
        begin
          l_d.rx = {l_q.rx[6:0], l_q.sdi_sy[1]};
        end
        if (!l_q.e[4])
        begin
          l_d.pin.sck = ~l_q.pin.sck;
          l_d.e = l_q.e + 5'h01;
          if (shift_w)
          begin
            l_d.pin.sdo = l_q.txr[7];
            l_d.txr = {l_q.txr[6:0], 1'b0};
          end
        end
        else
        begin
          l_d.done_tgl = ~l_q.done_tgl;
          l_d.state = sse_pkg::SSE_IDLE;
        end
      end
      default: l_d.state = sse_pkg::SSE_IDLE;
    endcase
    // reset held for two link edges through its own synchroniser
    if (l_q.rst_sy[1])
    begin
      l_d = '0;
      l_d.rst_sy = {l_q.rst_sy[0], rst};
    end
  end

  always_ff @(posedge link_clk)
  begin
    l_q <= l_d;
  end

  assign spi_o = l_q.pin;

  // checks on the register side
  a_slew_from_cfg: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 slew_ctrl_en == ($past(r_q.ctrl[sse_pkg::CTRL_I2C])
                         && !$past(r_q.status[sse_pkg::STAT_SMP])))
    else $error("slew control does not follow mode and sample phase");

  a_full_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    done_evt |=> r_q.status[sse_pkg::STAT_BF])
    else $error("completed byte lost its full flag");

  // checks on the link side
  a_i2c_no_shift: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    (l_q.state == sse_pkg::SSE_IDLE && l_q.c2.i2c) |=> l_q.state == sse_pkg::SSE_IDLE)
    else $error("shifter started in i2c use");

  a_mid_sample: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    (l_q.state == sse_pkg::SSE_SHIFT && !l_q.c2.input_sample_phase && shift_w) |-> !samp_w)
    else $error("middle sampling taken on a shift edge");

  a_end_sample: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    (l_q.state == sse_pkg::SSE_SHIFT && l_q.c2.input_sample_phase && !l_q.e[4] && !shift_w) |-> !samp_w)
    else $error("end sampling taken between shift edges");

  a_fall_tx: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    (l_q.c2.clock_idle_polarity && l_q.c2.cke && $past(l_q.state) == sse_pkg::SSE_SHIFT
     && $changed(spi_o.sdo)) |-> $fell(spi_o.sck))
    else $error("data changed off the falling edge");

  a_rise_tx: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    ((l_q.c2.clock_idle_polarity ^ l_q.c2.cke) && $past(l_q.state) == sse_pkg::SSE_SHIFT
     && $changed(spi_o.sdo)) |-> $rose(spi_o.sck))
    else $error("data changed off the rising edge");

  sequence s_load;
    l_q.state == sse_pkg::SSE_IDLE ##1 l_q.state == sse_pkg::SSE_SHIFT && l_q.e == 5'h00;
  endsequence

  sequence s_byte_end;
    ##16 l_q.e == sse_pkg::EDGE_LAST ##1 l_q.state == sse_pkg::SSE_IDLE;
  endsequence

  a_byte_length: assert property (@(posedge link_clk) disable iff (l_q.rst_sy[1])
    s_load |-> s_byte_end)
    else $error("byte did not take sixteen clock edges");

endmodule

/* sse_pkg.sv */
// shared constants and types for the serial port status and shift block
// assumes an ahb-lite host on ref_clk and a free-running link clock
package sse_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0094;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0098;
  localparam logic [31:0] ADDR_DATA = 32'h0000_009c;
  // status field positions and reset
  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF = 0;
  localparam logic [7:0] STAT_RST = 8'h00;
  // control field positions and reset
  localparam int CTRL_EN = 0;
  localparam int CTRL_I2C = 1;
  localparam int CTRL_CKP = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h07;
  // shift timing: one bit per two link clock edges
  localparam logic [4:0] EDGE_LAST = 5'h10;

  typedef enum logic [0:0] {SSE_IDLE, SSE_SHIFT} sse_state_t;

  typedef struct packed {
    logic input_sample_phase;
    logic cke;
    logic clock_idle_polarity;
    logic i2c;
    logic en;
  } sse_cfg_t;

  typedef struct packed {
    logic sck;
    logic sdo;
  } sse_spi_out_t;

  // register-clock domain state
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic start_tgl;
    logic [2:0] done_sy;
    logic aw;
    logic [31:0] aaddr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic slew;
  } sse_ref_t;

  // link-clock domain state
  typedef struct packed {
    logic [1:0] rst_sy;
    sse_cfg_t c1;
    sse_cfg_t c2;
    logic [2:0] st_sy;
    logic [1:0] sdi_sy;
    sse_state_t state;
    logic [4:0] e;
    logic [7:0] txr;
    logic [7:0] rx;
    sse_spi_out_t pin;
    logic done_tgl;
  } sse_lnk_t;

  localparam sse_ref_t REF_RST = '{status: STAT_RST, ctrl: CTRL_RST, ready: 1'b1,
                                   default: '0};
endpackage

/* sse_spi_peer.sv */
// spi peripheral model for the serial port bench
// assumes sck idles at the level of ckp and the port is the master
`timescale 1ns/1ns
module sse_spi_peer (
  // serial link
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  // mode and return level
  input wire logic clock_idle_polarity,
  input wire logic cke,
  input wire logic fill,
  output logic [7:0] got
);
  // sample opposite the transmit edge; stray edges fall off the top
  always @(posedge sck)
    if (clock_idle_polarity == cke) got <= {got[6:0], sdo};
  always @(negedge sck)
    if (clock_idle_polarity != cke) got <= {got[6:0], sdo};
  // constant level, so the stale input sync cannot skew the byte
  assign sdi = fill;
endmodule

/* sse_status_port_tb_top.sv */
// self-checking bench for the serial port status and shift block
// assumes a free-running link clock and a zero-wait ahb-lite slave
`timescale 1ns/1ns
module sse_status_port_tb_top;
  logic ref_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic slew_ctrl_en;
  logic sdi;
  logic fill = 1'h0;
  logic clock_idle_polarity = 1'h0;
  logic cke = 1'h0;
  logic [7:0] got;
  logic [7:0] tx;
  sse_pkg::sse_spi_out_t spi_o;
  int err_count = 0;
  int samples_checked = 0;

  // register clock, and a link clock offset so edges never coincide
  always #2 ref_clk = ~ref_clk;
  initial
  begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  sse_status_port dut (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sdi(sdi), .spi_o(spi_o), .slew_ctrl_en(slew_ctrl_en));

  sse_spi_peer peer (.sck(spi_o.sck), .sdo(spi_o.sdo), .sdi(sdi), .clock_idle_polarity(clock_idle_polarity), .cke(cke),
    .fill(fill), .got(got));

  task automatic test_done;
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'h1 && n < 100);
    rd = hrdata;
    if (n >= 100)
    begin
      err_count++;
      test_done();
    end
  endtask

  // poll until the buffer-full flag shows
  task automatic wait_full;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'h1 && n < 400)
    begin
      bus(1'h0, sse_pkg::ADDR_STATUS, 32'h0);
      n++;
    end
    if (n >= 400)
    begin
      err_count++;
      test_done();
    end
  endtask

  initial
  begin
    // long reset so the link side sees it through its sync
    repeat (64) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (4) @(posedge link_clk);
    @(posedge ref_clk);
    chk(hresp, 32'h0);
    bus(1'h0, sse_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, sse_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'h1, sse_pkg::ADDR_STATUS, 32'hff);
    bus(1'h0, sse_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'hc0);
    bus(1'h1, 32'ha0, 32'hff);
    bus(1'h0, 32'ha0, 32'h0);
    chk(rd, 32'h0);
    // all four clock modes, sample phase set only in the two idle-high modes
    for (int m = 0; m < 4; m++)
    begin
      clock_idle_polarity <= m[1];
      cke <= m[0];
      fill <= m[0];
      tx = 8'h69 ^ 8'(m * 17);
      bus(1'h1, sse_pkg::ADDR_CTRL, {29'h0, m[1], 2'h1});
      bus(1'h1, sse_pkg::ADDR_STATUS, {24'h0, m[1], m[0], 6'h0});
      repeat (8) @(posedge link_clk);
      @(posedge ref_clk);
      bus(1'h1, sse_pkg::ADDR_DATA, {24'h0, tx});
      wait_full();
      chk(got, tx);
      chk(spi_o.sck, m[1]);
      bus(1'h0, sse_pkg::ADDR_DATA, 32'h0);
      chk(rd, {24'h0, {8{fill}}});
      bus(1'h0, sse_pkg::ADDR_STATUS, 32'h0);
      chk(rd[0], 32'h0);
    end
    // i2c mode: no serial clocks, slew follows the sample phase
    bus(1'h1, sse_pkg::ADDR_CTRL, 32'h3);
    bus(1'h1, sse_pkg::ADDR_STATUS, 32'h0);
    bus(1'h1, sse_pkg::ADDR_DATA, 32'h3c);
    wait_full();
    chk(got, tx);
    bus(1'h0, sse_pkg::ADDR_DATA, 32'h0);
    chk(rd, 32'hff);
    chk(slew_ctrl_en, 32'h1);
    bus(1'h1, sse_pkg::ADDR_STATUS, 32'h80);
    repeat (2) @(posedge ref_clk);
    chk(slew_ctrl_en, 32'h0);
    bus(1'h1, sse_pkg::ADDR_STATUS, 32'h0);
    bus(1'h1, sse_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(slew_ctrl_en, 32'h0);
    test_done();
  end
endmodule
